// ---- hdl/cffi_top.v ----
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cffi_regs.vh"

module cffi_top (
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // analog comparator levels
  input  wire        vin_uvlo_ok,
  input  wire        vin_slp_ok,
  input  wire        vin_ovp_ok,
  input  wire        ts_warm_in,
  input  wire        ts_hot_in,
  input  wire        ts_open_in,
  input  wire        die_overtemp_shutdown,
  input  wire        ldo_ocp_in,
  // pins
  input  wire        pushbutton_input,
  input  wire        charge_enable_pin,
  // same-clock event pulses
  input  wire        adc_done,
  input  wire [2:0]  comp_alarm,
  // outputs
  output wire        input_good_indicator_out,
  output reg         input_good_indicator_oe,
  output wire        host_alert,
  output reg         charge_allow,
  output reg         timer_running
);

  // functions
  function [31:0] pad_flags;
    input [`CFFI_FLG_W-1:0] f;
    begin
      pad_flags = {{(32-`CFFI_FLG_W){1'b0}}, f};
    end
  endfunction

  function sel_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel_hit = (a[11:2] == ofs[11:2]);
    end
  endfunction

  localparam integer US_CYC = `CFFI_US_CYCLES;
  localparam [5:0] US_LAST = US_CYC[5:0] - 6'h01;

  // input synchronisers
  wire [`CFFI_IN_W-1:0] raw_in;
  wire [`CFFI_IN_W-1:0] syn;

  assign raw_in[`CFFI_IN_UVLO_OK] = vin_uvlo_ok;
  assign raw_in[`CFFI_IN_SLP_OK]  = vin_slp_ok;
  assign raw_in[`CFFI_IN_OVP_OK]  = vin_ovp_ok;
  assign raw_in[`CFFI_IN_BUTTON]  = pushbutton_input;
  assign raw_in[`CFFI_IN_CHG_EN]  = charge_enable_pin;
  assign raw_in[`CFFI_IN_TS_WARM] = ts_warm_in;
  assign raw_in[`CFFI_IN_TS_HOT]  = ts_hot_in;
  assign raw_in[`CFFI_IN_TS_OPEN] = ts_open_in;
  assign raw_in[`CFFI_IN_DIE_OT]  = die_overtemp_shutdown;
  assign raw_in[`CFFI_IN_LDO_OCP] = ldo_ocp_in;

  cffi_sync #(
    .W (`CFFI_IN_W)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (raw_in),
    .q     (syn)
  );

  wire supply_valid = syn[`CFFI_IN_UVLO_OK] & syn[`CFFI_IN_SLP_OK]
                    & syn[`CFFI_IN_OVP_OK];
  wire chg_en       = syn[`CFFI_IN_CHG_EN];
  wire ts_pause     = syn[`CFFI_IN_TS_HOT] | syn[`CFFI_IN_TS_OPEN];
  wire die_ot       = syn[`CFFI_IN_DIE_OT];

  // delayed copies for edge detection
  reg [`CFFI_IN_W-1:0] syn_d_r;
  reg                  valid_d_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      syn_d_r   <= {`CFFI_IN_W{1'b0}};
      valid_d_r <= 1'b0;
    end else begin
      syn_d_r   <= syn;
      valid_d_r <= supply_valid;
    end
  end

  wire [`CFFI_IN_W-1:0] syn_rise = syn & ~syn_d_r;
  wire supply_toggle = supply_valid ^ valid_d_r;
  wire chg_en_toggle = chg_en ^ syn_d_r[`CFFI_IN_CHG_EN];

  // microsecond tick
  reg [5:0] us_cnt_r;
  reg       us_tick_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_cnt_r  <= 6'h00;
      us_tick_r <= 1'b0;
    end else if (us_cnt_r == US_LAST) begin
      us_cnt_r  <= 6'h00;
      us_tick_r <= 1'b1;
    end else begin
      us_cnt_r  <= us_cnt_r + 6'h01;
      us_tick_r <= 1'b0;
    end
  end

  // ahb-lite slave, zero wait states
  reg        wr_pend_r;
  reg [11:0] wr_addr_r;

  reg [2:0]  ctrl_r;
  reg [31:0] tmr_limit_r;

  wire acc    = hsel & hready & htrans[1];
  wire rd_acc = acc & ~hwrite;
  wire wr_acc = acc & hwrite;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= wr_acc;
      if (wr_acc) begin
        wr_addr_r <= haddr;
      end
    end
  end

  wire wr_ctrl  = wr_pend_r & sel_hit(wr_addr_r, `CFFI_OFS_CTRL);
  wire wr_limit = wr_pend_r & sel_hit(wr_addr_r, `CFFI_OFS_TMR_LIMIT);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r      <= `CFFI_CTRL_RST;
      tmr_limit_r <= `CFFI_TMR_LIMIT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[2:0];
      end
      if (wr_limit) begin
        tmr_limit_r <= hwdata;
      end
    end
  end

  // flags
  reg  [`CFFI_FLG_W-1:0] flags_r;
  reg  [`CFFI_FLG_W-1:0] flags_nxt;
  reg  [`CFFI_FLG_W-1:0] set_ev;
  wire                   tmr_expire;

  wire rd_flags = rd_acc & sel_hit(haddr, `CFFI_OFS_FLAGS);

  always @* begin
    set_ev = {`CFFI_FLG_W{1'b0}};
    set_ev[`CFFI_FLG_ADC_READY] = adc_done;
    set_ev[`CFFI_FLG_COMP1]     = comp_alarm[0];
    set_ev[`CFFI_FLG_COMP2]     = comp_alarm[1];
    set_ev[`CFFI_FLG_COMP3]     = comp_alarm[2];
    set_ev[`CFFI_FLG_TS_WARM]   = syn_rise[`CFFI_IN_TS_WARM];
    set_ev[`CFFI_FLG_TS_HOT]    = syn_rise[`CFFI_IN_TS_HOT];
    set_ev[`CFFI_FLG_TS_OPEN]   = syn_rise[`CFFI_IN_TS_OPEN];
    set_ev[`CFFI_FLG_TMR_EXP]   = tmr_expire;
    set_ev[`CFFI_FLG_LDO_OCP]   = syn_rise[`CFFI_IN_LDO_OCP];
  end

  // cleared only by read, set wins
  always @* begin
    flags_nxt = flags_r;
    if (rd_flags) begin
      flags_nxt = {`CFFI_FLG_W{1'b0}};
    end
    flags_nxt = flags_nxt | set_ev;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= {`CFFI_FLG_W{1'b0}};
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // alert pulse on any flag rising edge
  reg alert_trig_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_trig_r <= 1'b0;
    end else begin
      alert_trig_r <= |(flags_nxt & ~flags_r);
    end
  end

  cffi_pulse u_alert (
    .clk   (hclk),
    .rst_n (hresetn),
    .trig  (alert_trig_r),
    .tick  (us_tick_r),
    .pulse (host_alert)
  );

  // charge safety timer
  reg        block_r;
  reg [31:0] tmr_cnt_r;

  wire exp_flag = flags_r[`CFFI_FLG_TMR_EXP];
  wire chg_req  = supply_valid & chg_en & ~die_ot;
  wire charging = chg_req & ~block_r & ~ts_pause;
  wire tmr_hit  = (tmr_cnt_r >= tmr_limit_r);

  assign tmr_expire = charging & us_tick_r & tmr_hit & ~exp_flag;

  // block until supply or enable toggles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_r <= 1'b0;
    end else if (tmr_expire) begin
      block_r <= 1'b1;
    end else if (supply_toggle | chg_en_toggle) begin
      block_r <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_cnt_r <= 32'h0000_0000;
    end else if (exp_flag | block_r | ~chg_req) begin
      tmr_cnt_r <= 32'h0000_0000;
    end else if (charging & us_tick_r & ~tmr_hit) begin
      tmr_cnt_r <= tmr_cnt_r + 32'h0000_0001;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charge_allow  <= 1'b0;
      timer_running <= 1'b0;
    end else begin
      charge_allow  <= charging & ~tmr_expire;
      timer_running <= charging & ~exp_flag;
    end
  end

  // open-drain indicator
  reg ind_oe_nxt;

  always @* begin
    case (ctrl_r[`CFFI_CTRL_SEL_MSB:`CFFI_CTRL_SEL_LSB])
      `CFFI_SEL_SUPPLY: ind_oe_nxt = supply_valid;
      `CFFI_SEL_BUTTON: ind_oe_nxt = ~syn[`CFFI_IN_BUTTON];
      default:          ind_oe_nxt = ~ctrl_r[`CFFI_CTRL_DRIVE];
    endcase
  end

  assign input_good_indicator_out = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_good_indicator_oe <= 1'b0;
    end else begin
      input_good_indicator_oe <= ind_oe_nxt;
    end
  end

  // read data, registered in the address phase
  reg [31:0] rd_nxt;
  wire [31:0] status_w;

  assign status_w = {19'h00000, input_good_indicator_oe, exp_flag, block_r,
                     timer_running, charge_allow, supply_valid, syn[9:5],
                     syn[`CFFI_IN_CHG_EN], syn[`CFFI_IN_BUTTON]};

  always @* begin
    rd_nxt = 32'h0000_0000;
    if (sel_hit(haddr, `CFFI_OFS_FLAGS)) begin
      rd_nxt = pad_flags(flags_r);
    end else if (sel_hit(haddr, `CFFI_OFS_STATUS)) begin
      rd_nxt = status_w;
    end else if (sel_hit(haddr, `CFFI_OFS_CTRL)) begin
      rd_nxt = {29'h0000_0000, ctrl_r};
    end else if (sel_hit(haddr, `CFFI_OFS_TMR_LIMIT)) begin
      rd_nxt = tmr_limit_r;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      hrdata <= rd_nxt;
    end
  end

endmodule // cffi_top

`default_nettype wire

// ---- hdl/cffi_regs.vh ----
// How it works
// - conversion done sets flag, interrupts, nothing else
// - timer expiry flags, blocks charge until toggle
// - indicator only pulls low or floats
// - source 00: low while supply valid
// - source 01: mirrors pushbutton input level
// - source 1x: follows indicator drive bit
// - TS warm, hot or open fault emits fixed alert pulse; die overtemp sets no flag and emits none
// - fault flags latched until host reads
`ifndef CFFI_REGS_VH
`define CFFI_REGS_VH

// register byte offsets
`define CFFI_OFS_FLAGS      12'h000
`define CFFI_OFS_STATUS     12'h004
`define CFFI_OFS_CTRL       12'h008
`define CFFI_OFS_TMR_LIMIT  12'h00c

// flag register bit positions
`define CFFI_FLG_ADC_READY  0
`define CFFI_FLG_COMP1      1
`define CFFI_FLG_COMP2      2
`define CFFI_FLG_COMP3      3
`define CFFI_FLG_TS_WARM    4
`define CFFI_FLG_TS_HOT     5
`define CFFI_FLG_TS_OPEN    6
`define CFFI_FLG_TMR_EXP    7
`define CFFI_FLG_LDO_OCP    8
`define CFFI_FLG_W          9

// control register fields
`define CFFI_CTRL_SEL_LSB   0
`define CFFI_CTRL_SEL_MSB   1
`define CFFI_CTRL_DRIVE     2
`define CFFI_CTRL_RST       3'h0

// indicator source codes
`define CFFI_SEL_SUPPLY     2'h0
`define CFFI_SEL_BUTTON     2'h1

// safety timer limit reset, in microseconds
`define CFFI_TMR_LIMIT_RST  32'h0000_2710

// timing
`define CFFI_CLK_PERIOD_NS  20
`define CFFI_US_NS          1000
`define CFFI_US_CYCLES      (`CFFI_US_NS / `CFFI_CLK_PERIOD_NS)
`define CFFI_ALERT_US       128

// synchronised input positions
`define CFFI_IN_UVLO_OK     0
`define CFFI_IN_SLP_OK      1
`define CFFI_IN_OVP_OK      2
`define CFFI_IN_BUTTON      3
`define CFFI_IN_CHG_EN      4
`define CFFI_IN_TS_WARM     5
`define CFFI_IN_TS_HOT      6
`define CFFI_IN_TS_OPEN     7
`define CFFI_IN_DIE_OT      8
`define CFFI_IN_LDO_OCP     9
`define CFFI_IN_W           10

`endif

// ---- hdl/cffi_sync.v ----
`timescale 1ns/1ps
`default_nettype none

module cffi_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // cffi_sync

`default_nettype wire

// ---- hdl/cffi_pulse.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cffi_regs.vh"

module cffi_pulse (
  input  wire clk,
  input  wire rst_n,
  input  wire trig,
  input  wire tick,
  output reg  pulse
);

  localparam integer LEN_I = `CFFI_ALERT_US;
  localparam [7:0]   LEN   = LEN_I[7:0];

  reg [7:0] cnt_r;

  // retrigger restarts the full length
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      pulse <= 1'b0;
    end else if (trig) begin
      cnt_r <= 8'h00;
      pulse <= 1'b1;
    end else if (pulse && tick) begin
      if (cnt_r == LEN - 8'h01) begin
        pulse <= 1'b0;
        cnt_r <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

endmodule // cffi_pulse

`default_nettype wire

// ---- tb/cffi_props_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module cffi_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        vin_uvlo_ok,
  input wire        vin_slp_ok,
  input wire        vin_ovp_ok,
  input wire        pushbutton_input,
  input wire        input_good_indicator_out,
  input wire        input_good_indicator_oe,
  input wire        host_alert
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg        wr_ctrl_r;
  reg [2:0]  ctrl_r;
  reg [15:0] hi_cnt_r;
  wire       ok = vin_uvlo_ok & vin_slp_ok & vin_ovp_ok;
  wire       oe = input_good_indicator_oe;
  // shadow of the source select written over the bus
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_r <= 1'b0;
      ctrl_r <= 3'h0;
      hi_cnt_r <= 16'h0;
    end else begin
      wr_ctrl_r <= hsel & hready & htrans[1] & hwrite & (haddr[11:2] == 10'h2);
      if (wr_ctrl_r)
        ctrl_r <= hwdata[2:0];
      hi_cnt_r <= host_alert ? hi_cnt_r + 16'h1 : 16'h0;
    end
  end
  sequence s_sup_on;
    (ctrl_r[1:0] == 2'h0 && ok)[*4];
  endsequence
  sequence s_drv;
    (ctrl_r[1] && $stable(ctrl_r))[*4];
  endsequence
  AST_PIN_NEVER_HIGH: assert property (input_good_indicator_out == 1'b0)
    else $error("indicator data not low");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  AST_SUPPLY_ON: assert property (s_sup_on |-> oe)
    else $error("valid supply but pin floats");
  AST_SUPPLY_OFF: assert property ((ctrl_r[1:0] == 2'h0 && !ok)[*4] |-> !oe)
    else $error("invalid supply but pin low");
  AST_BTN_LOW: assert property ((ctrl_r[1:0] == 2'h1 && !pushbutton_input)[*4] |-> oe)
    else $error("button low but pin floats");
  AST_BTN_HIGH: assert property ((ctrl_r[1:0] == 2'h1 && pushbutton_input)[*4] |-> !oe)
    else $error("button high but pin low");
  AST_DRIVE: assert property (s_drv |-> oe == !ctrl_r[2])
    else $error("pin not following drive bit");
  AST_ALERT_LEN: assert property ($fell(host_alert) |-> hi_cnt_r >= 16'd6336)
    else $error("alert pulse too short");
endmodule // cffi_props
bind cffi_top cffi_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .vin_uvlo_ok(vin_uvlo_ok),
  .vin_slp_ok(vin_slp_ok), .vin_ovp_ok(vin_ovp_ok), .pushbutton_input(pushbutton_input),
  .input_good_indicator_out(input_good_indicator_out),
  .input_good_indicator_oe(input_good_indicator_oe), .host_alert(host_alert));
`default_nettype wire

// ---- tb/cffi_pin_pullup.sv ----
`timescale 1ns/1ps
`default_nettype none
module cffi_pin_pullup (
  input  wire oe,
  input  wire dout,
  output wire pin
);
  assign pin = oe ? (dout ? 1'bx : 1'b0) : 1'b1;
endmodule // cffi_pin_pullup
`default_nettype wire

// ---- tb/charger_fault_flags_and_indicator_pin_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cffi_regs.vh"
module charger_fault_flags_and_indicator_pin_tb;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [11:0] haddr = 12'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [2:0]  hsize = 3'h0;
  reg  [2:0]  input_supply = 3'h7;
  reg         btn = 1'b1;
  reg         chg_en = 1'b1;
  reg         ts_hot = 1'b0;
  reg         adc = 1'b0;
  reg  [2:0]  comp = 3'h0;
  wire [31:0] hrdata;
  wire        hready, hresp, pin_out, pin_oe, pin, alert, chg_ok, tmr_run;
  integer     error_cnt = 0;
  integer     n_checks = 0;
  integer     seed = 32'h5d258a3a;
  integer     i, k;
  reg  [31:0] q, r;
  reg         b;

  always #10 hclk = ~hclk;

  cffi_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .vin_uvlo_ok(input_supply[0]),
    .vin_slp_ok(input_supply[1]), .vin_ovp_ok(input_supply[2]), .ts_warm_in(1'b0), .ts_hot_in(ts_hot),
    .ts_open_in(1'b0), .die_overtemp_shutdown(1'b0), .ldo_ocp_in(1'b0),
    .pushbutton_input(btn), .charge_enable_pin(chg_en), .adc_done(adc),
    .comp_alarm(comp), .input_good_indicator_out(pin_out),
    .input_good_indicator_oe(pin_oe), .host_alert(alert), .charge_allow(chg_ok),
    .timer_running(tmr_run));
  cffi_pin_pullup pu_u (.oe(pin_oe), .dout(pin_out), .pin(pin));

  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
    end
  endtask

  task rd(input [11:0] a, input [31:0] e, input string nm);
    begin
      xfer(1'b0, a, 32'h0);
      chk(nm, e, q);
    end
  endtask

  function exp_oe(input [2:0] c, input [2:0] v, input bt);
    exp_oe = c[1] ? !c[2] : (c[0] ? !bt : (v == 3'h7));
  endfunction

  initial begin
    #(30000 * 20);
    error_cnt = error_cnt + 1;
    $display("BAD watchdog expired");
    summarize;
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CFFI_OFS_CTRL, 32'h0, "ctrl reset");
    rd(`CFFI_OFS_TMR_LIMIT, `CFFI_TMR_LIMIT_RST, "limit reset");
    rd(12'h010, 32'h0, "unmapped");
    xfer(1'b1, `CFFI_OFS_FLAGS, 32'h1ff);
    rd(`CFFI_OFS_FLAGS, 32'h0, "flags read only");
    chk("pin supply", 32'h0, pin);
    $display("test reset done");
    xfer(1'b1, `CFFI_OFS_TMR_LIMIT, 32'h5);
    chk("charge on", 32'h1, chg_ok);
    chk("timer on", 32'h1, tmr_run);
    for (k = 0; k < 2000 && chg_ok === 1'b1; k = k + 1) @(posedge hclk);
    chk("charge expired", 32'h0, chg_ok);
    repeat (20) @(posedge hclk);
    rd(`CFFI_OFS_FLAGS, 32'h80, "timer flag");
    repeat (20) @(posedge hclk);
    chk("charge blocked", 32'h0, chg_ok);
    chk("timer stopped", 32'h0, tmr_run);
    rd(`CFFI_OFS_STATUS, 32'h1483, "status blocked");
    chg_en <= 1'b0;
    repeat (6) @(posedge hclk);
    chg_en <= 1'b1;
    for (k = 0; k < 20 && chg_ok !== 1'b1; k = k + 1) @(posedge hclk);
    chk("charge released", 32'h1, chg_ok);
    xfer(1'b1, `CFFI_OFS_TMR_LIMIT, `CFFI_TMR_LIMIT_RST);
    $display("test timer done");
    for (k = 0; k < 8000 && alert !== 1'b0; k = k + 1) @(posedge hclk);
    ts_hot <= 1'b1;
    for (k = 0; k < 10 && alert !== 1'b1; k = k + 1) @(posedge hclk);
    ts_hot <= 1'b0;
    for (k = 0; k < 7000 && alert === 1'b1; k = k + 1) @(posedge hclk);
    b = (k >= 6336 && k <= 6464);
    chk("alert length", 32'h1, b);
    rd(`CFFI_OFS_FLAGS, 32'h20, "hot flag");
    rd(`CFFI_OFS_FLAGS, 32'h0, "hot cleared");
    $display("test fault done");
    b = chg_ok;
    adc <= 1'b1;
    comp <= 3'h7;
    @(posedge hclk);
    adc <= 1'b0;
    comp <= 3'h0;
    for (k = 0; k < 4 && alert !== 1'b1; k = k + 1) @(posedge hclk);
    chk("adc alert", 32'h1, alert);
    rd(`CFFI_OFS_FLAGS, 32'hf, "adc flags");
    chk("adc no effect", b, chg_ok);
    $display("test conversion done");
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      xfer(1'b1, `CFFI_OFS_CTRL, {29'h0, r[2], i[1:0]});
      input_supply <= r[6] ? 3'h7 : r[5:3];
      btn <= r[7];
      repeat (6) @(posedge hclk);
      chk("pin level", !exp_oe({r[2], i[1:0]}, input_supply, btn), pin);
    end
    $display("test indicator done");
    summarize;
  end
endmodule // charger_fault_flags_and_indicator_pin_tb
`default_nettype wire
